// ===== rtl/pvi_unit.sv
// Prioritized vector interrupt unit: request latches, masking, priority,
// acceptance sequence with stack pushes and vector fetch.
// Assumes memory answers a read one cycle after mem_rd and takes writes at once.
`timescale 1ns/1ps

module pvi_unit (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // External pin sources
    input  wire logic                ext_pin_irq_a,
    input  wire logic                ext_pin_irq_b,
    input  wire logic                ext_pin_irq_c,
    input  wire logic                counter_pin_a,
    input  wire logic                counter_pin_b,
    input  wire logic [4:0]          edge_fall_sel,
    input  wire logic [7:0]          keypad_port,
    input  wire logic [7:0]          keypad_dir,
    // Internal peripheral sources
    input  wire logic                serial_done,
    input  wire logic                serial_sel,
    input  wire logic                timer_a_uflow,
    input  wire logic [5:0]          timer8_uflow,
    input  wire logic                adc_done,
    input  wire logic                adc_sel,
    input  wire logic                software_break,
    // Software access to enables and requests
    input  wire logic                enable_wr,
    input  wire logic [14:0]         enable_wdata,
    input  wire logic                req_wr,
    input  wire logic [14:0]         req_wdata,
    input  wire logic                i_flag_set,
    input  wire logic                i_flag_clr,
    // CPU core state
    input  wire logic                instr_boundary,
    input  wire logic [15:0]         pc_in,
    input  wire logic [7:0]          sp_in,
    input  wire logic [7:0]          ps_in,
    input  wire logic                stack_page,
    // Memory port
    input  wire logic [7:0]          mem_rdata,
    output logic [15:0]              mem_addr,
    output logic [7:0]               mem_wdata,
    output logic                     mem_wr,
    output logic                     mem_rd,
    // CPU core control
    output logic                     halt,
    output logic [15:0]              pc_out,
    output logic                     pc_load,
    output logic [7:0]               sp_out,
    output logic                     sp_load,
    output logic                     i_flag,
    output logic [3:0]               grant_src,
    // Status
    output logic [14:0]              req_status,
    output logic [14:0]              enable_status
);

    import pvi_pkg::*;

    // ------------------------------------------------------------
    // Edge sources
    // ------------------------------------------------------------
    logic [N_EDGE-1:0] edge_level;
    logic [N_EDGE-1:0] edge_sel;
    logic [N_EDGE-1:0] edge_hit;
    logic              key_and;

    // Pins set as outputs count as high in the key AND
    assign key_and    = &(keypad_port | keypad_dir);
    assign edge_level = {key_and, counter_pin_b, counter_pin_a,
                         ext_pin_irq_c, ext_pin_irq_b, ext_pin_irq_a};
    assign edge_sel   = {1'b1, edge_fall_sel};

    genvar gi;
    generate
        for (gi = 0; gi < N_EDGE; gi++) begin : g_edge
            pvi_edge_det u_edge (
                .core_clk (core_clk),
                .rst      (rst),
                .level    (edge_level[gi]),
                .fall_sel (edge_sel[gi]),
                .edge_hit (edge_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Request set events
    // ------------------------------------------------------------
    logic [N_MASK-1:0] req_set;
    logic [N_MASK-1:0] req_clr;
    logic [N_MASK-1:0] req;
    logic [N_MASK-1:0] enable;
    logic              break_pend;

    always_comb begin
        req_set                                  = '0;
        req_set[SRC_PIN_A]                       = edge_hit[0];
        req_set[SRC_PIN_B]                       = edge_hit[1];
        req_set[SRC_PIN_C]                       = edge_hit[2];
        req_set[SRC_SERIAL]                      = serial_done & serial_sel;
        req_set[SRC_TIMER_A]                     = timer_a_uflow;
        req_set[SRC_TIMER8_0 +: 6]               = timer8_uflow;
        req_set[SRC_CNTR_A]                      = edge_hit[3];
        req_set[SRC_CNTR_B]                      = edge_hit[4];
        req_set[SRC_KEY]                         = edge_hit[5];
        req_set[SRC_ADC]                         = adc_done & adc_sel;
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    pvi_state_e  state;
    logic [3:0]  src;
    logic        src_is_break;
    logic        is_reset_seq;
    logic [15:0] pc_stash;
    logic [7:0]  sp_cnt;
    logic [15:0] vec_lo;
    logic [7:0]  pc_lo;
    logic        accept_now;

    // Acceptance effects land while the status byte is on the bus
    assign accept_now = (state == ST_PUSH_PS);

    // ------------------------------------------------------------
    // Request latches
    // ------------------------------------------------------------
    always_comb begin
        req_clr = '0;
        if (req_wr) begin
            req_clr = ~req_wdata;
        end
        if (accept_now && !src_is_break) begin
            req_clr[src] = 1'b1;
        end
    end

    // Set wins over clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req <= RST_REQ;
        end else begin
            req <= (req & ~req_clr) | req_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            break_pend <= 1'b0;
        end else if (software_break) begin
            break_pend <= 1'b1;
        end else if (accept_now && src_is_break) begin
            break_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Enable bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enable <= RST_ENABLE;
        end else if (enable_wr) begin
            enable <= enable_wdata;
        end
    end

    // ------------------------------------------------------------
    // Global mask flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            i_flag <= RST_I_FLAG;
        end else if (accept_now || i_flag_set) begin
            i_flag <= 1'b1;
        end else if (i_flag_clr) begin
            i_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------
    logic [N_SRC-1:0] cand;
    logic             win_any;
    logic [3:0]       win_idx;

    always_comb begin
        cand          = '0;
        cand[N_MASK-1:0] = req & enable & {N_MASK{~i_flag}};
        cand[SRC_BREAK]  = break_pend;
        win_any       = 1'b0;
        win_idx       = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                win_any = 1'b1;
                win_idx = 4'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // Winner vector and grant
    // ------------------------------------------------------------
    logic [15:0] win_vec;
    logic        grant_now;

    // Each step down in priority sits one vector pair lower
    always_comb begin
        win_vec = VEC_FIRST_LO - VEC_STEP * 16'(win_idx);
    end

    assign grant_now = instr_boundary & win_any & (state == ST_IDLE);

    // ------------------------------------------------------------
    // Acceptance sequence
    // ------------------------------------------------------------
    logic [7:0] stack_hi;
    logic [7:0] ps_push;

    assign stack_hi = stack_page ? STACK_PAGE_1 : STACK_PAGE_0;

    always_comb begin
        ps_push           = ps_in;
        ps_push[PS_BIT_I] = i_flag;
        ps_push[PS_BIT_B] = src_is_break;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state        <= ST_RESET;
            src          <= 4'h0;
            src_is_break <= 1'b0;
            is_reset_seq <= 1'b1;
            pc_stash     <= 16'h0000;
            sp_cnt       <= 8'h00;
            vec_lo       <= 16'h0000;
            pc_lo        <= 8'h00;
            mem_addr     <= 16'h0000;
            mem_wdata    <= 8'h00;
            mem_wr       <= 1'b0;
            mem_rd       <= 1'b0;
            halt         <= 1'b1;
            pc_out       <= 16'h0000;
            pc_load      <= 1'b0;
            sp_out       <= 8'h00;
            sp_load      <= 1'b0;
            grant_src    <= 4'h0;
        end else begin
            pc_load <= 1'b0;
            sp_load <= 1'b0;
            case (state)
                ST_RESET: begin
                    state        <= ST_VEC_LO;
                    is_reset_seq <= 1'b1;
                    vec_lo       <= VEC_RESET_LO;
                    mem_addr     <= VEC_RESET_LO;
                    mem_rd       <= 1'b1;
                    halt         <= 1'b1;
                end
                ST_IDLE: begin
                    if (grant_now) begin
                        state        <= ST_PUSH_PCH;
                        halt         <= 1'b1;
                        src          <= win_idx;
                        grant_src    <= win_idx;
                        src_is_break <= (win_idx == 4'(SRC_BREAK));
                        is_reset_seq <= 1'b0;
                        vec_lo       <= win_vec;
                        pc_stash     <= pc_in;
                        mem_addr     <= {stack_hi, sp_in};
                        mem_wdata    <= pc_in[15:8];
                        mem_wr       <= 1'b1;
                        sp_cnt       <= sp_in - 8'h01;
                    end
                end
                ST_PUSH_PCH: begin
                    state     <= ST_PUSH_PCL;
                    mem_addr  <= {stack_hi, sp_cnt};
                    mem_wdata <= pc_stash[7:0];
                    sp_cnt    <= sp_cnt - 8'h01;
                end
                ST_PUSH_PCL: begin
                    state     <= ST_PUSH_PS;
                    mem_addr  <= {stack_hi, sp_cnt};
                    mem_wdata <= ps_push;
                    sp_cnt    <= sp_cnt - 8'h01;
                end
                ST_PUSH_PS: begin
                    state    <= ST_VEC_LO;
                    mem_wr   <= 1'b0;
                    mem_addr <= vec_lo;
                    mem_rd   <= 1'b1;
                end
                ST_VEC_LO: begin
                    state    <= ST_VEC_HI;
                    mem_addr <= vec_lo + 16'h0001;
                    mem_rd   <= 1'b1;
                end
                ST_VEC_HI: begin
                    state  <= ST_VEC_DATA;
                    pc_lo  <= mem_rdata;
                    mem_rd <= 1'b0;
                end
                ST_VEC_DATA: begin
                    state   <= ST_IDLE;
                    pc_out  <= {mem_rdata, pc_lo};
                    pc_load <= 1'b1;
                    sp_out  <= sp_cnt;
                    sp_load <= ~is_reset_seq;
                    halt    <= 1'b0;
                end
                default: begin
                    state  <= ST_IDLE;
                    mem_wr <= 1'b0;
                    mem_rd <= 1'b0;
                    halt   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_status <= RST_REQ;
        end else begin
            req_status <= req;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enable_status <= RST_ENABLE;
        end else begin
            enable_status <= enable;
        end
    end

endmodule : pvi_unit

// ===== pkg/pvi_pkg.sv
// Constants, indices and vector layout of the prioritized vector interrupt unit.
// Assumes one 200 MHz clock, CPU core and memory outside on plain ports.

package pvi_pkg;

    // ------------------------------------------------------------
    // Source indices
    // ------------------------------------------------------------
    localparam int N_SRC        = 16;
    localparam int N_MASK       = 15;
    localparam int N_EDGE       = 6;
    localparam int SRC_PIN_A    = 0;
    localparam int SRC_PIN_B    = 1;
    localparam int SRC_PIN_C    = 2;
    localparam int SRC_SERIAL   = 3;
    localparam int SRC_TIMER_A  = 4;
    localparam int SRC_TIMER8_0 = 5;
    localparam int SRC_CNTR_A   = 11;
    localparam int SRC_CNTR_B   = 12;
    localparam int SRC_KEY      = 13;
    localparam int SRC_ADC      = 14;
    localparam int SRC_BREAK    = 15;

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFC;
    localparam logic [15:0] VEC_FIRST_LO = 16'hFFFA;
    localparam logic [15:0] VEC_STEP     = 16'h0002;

    // ------------------------------------------------------------
    // Status byte and stack
    // ------------------------------------------------------------
    localparam int          PS_BIT_I      = 2;
    localparam int          PS_BIT_B      = 4;
    localparam logic [7:0]  STACK_PAGE_0  = 8'h00;
    localparam logic [7:0]  STACK_PAGE_1  = 8'h01;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [14:0] RST_ENABLE = 15'h0000;
    localparam logic [14:0] RST_REQ    = 15'h0000;
    localparam logic        RST_I_FLAG = 1'b1;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_PUSH_PCH,
        ST_PUSH_PCL,
        ST_PUSH_PS,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_VEC_DATA
    } pvi_state_e;

endpackage : pvi_pkg

// ===== rtl/pvi_edge_det.sv
// Edge detector with selectable active edge for one request source.
// Assumes the input is synchronous to core_clk.
`timescale 1ns/1ps

module pvi_edge_det (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Source
    input  wire logic level,
    input  wire logic fall_sel,
    // Event
    output logic      edge_hit
);

    logic adj;
    logic prev;
    logic primed;

    // Flipping the edge select flips adj and may itself look like an edge
    assign adj      = level ^ fall_sel;
    assign edge_hit = primed & adj & ~prev;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev   <= 1'b0;
            primed <= 1'b0;
        end else begin
            prev   <= adj;
            primed <= 1'b1;
        end
    end

endmodule : pvi_edge_det

// ===== sim/pvi_unit_props.sv
// Checker for the interrupt unit: acceptance sequence, pushes, vector fetch.
// Assumes binding to pvi_unit, single clock core_clk, reset rst.
`timescale 1ns/1ps

module pvi_unit_props (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Core side
    input  wire logic        stack_page,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic        halt,
    input  wire logic        pc_load,
    input  wire logic [7:0]  sp_out,
    input  wire logic        sp_load,
    input  wire logic        i_flag,
    input  wire logic [3:0]  grant_src,
    input  wire logic [14:0] req_status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_push_seq;
        $rose(mem_wr) |-> mem_wr [*3] ##1 (!mem_wr && mem_rd);
    endproperty
    property p_push_addr;
        $rose(mem_wr) |-> mem_addr[15:8] == {7'h00, stack_page}
            ##1 mem_addr == $past(mem_addr) - 16'h0001;
    endproperty
    property p_vec_pair;
        $rose(mem_rd) |=> mem_rd && mem_addr == $past(mem_addr) + 16'h0001;
    endproperty
    property p_vec_grant;
        $rose(mem_rd) && $past(mem_wr) |->
            mem_addr == 16'hFFFA - {11'h000, grant_src, 1'b0};
    endproperty
    property p_iflag;
        $fell(mem_wr) |-> i_flag;
    endproperty
    property p_req_clr;
        $fell(mem_wr) |=> grant_src == 4'hF || !req_status[grant_src];
    endproperty
    property p_brk_flag;
        $rose(mem_wr) |-> ##2 mem_wdata[4] == (grant_src == 4'hF);
    endproperty
    property p_halt_end;
        $fell(halt) |-> pc_load;
    endproperty
    property p_sp;
        sp_load |-> sp_out == $past(mem_addr[7:0], 4) - 8'h01;
    endproperty

    a_push_seq:  assert property (p_push_seq)  else $error("push sequence broken");
    a_push_addr: assert property (p_push_addr) else $error("push address wrong");
    a_vec_pair:  assert property (p_vec_pair)  else $error("vector pair wrong");
    a_vec_grant: assert property (p_vec_grant) else $error("vector not granted");
    a_iflag:     assert property (p_iflag)     else $error("mask flag not set");
    a_req_clr:   assert property (p_req_clr)   else $error("request not cleared");
    a_brk_flag:  assert property (p_brk_flag)  else $error("break flag wrong");
    a_halt_end:  assert property (p_halt_end)  else $error("halt ends without load");
    a_sp:        assert property (p_sp)        else $error("stack pointer wrong");

    c_brk:   cover property ($rose(mem_wr) && grant_src == 4'hF);
    c_page:  cover property ($rose(mem_wr) && stack_page);
    c_reset: cover property ($fell(halt) && !sp_load);
endmodule : pvi_unit_props

bind pvi_unit pvi_unit_props u_props (
    .core_clk(core_clk), .rst(rst), .stack_page(stack_page), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .halt(halt),
    .pc_load(pc_load), .sp_out(sp_out), .sp_load(sp_load), .i_flag(i_flag),
    .grant_src(grant_src), .req_status(req_status)
);

// ===== sim/pvi_mem_model.sv
// Memory model answering vector reads; byte at address a is a[7:0] ^ A5.
// Assumes read data due one cycle after mem_rd; idle bus shows inverse.
`timescale 1ns/1ps

module pvi_mem_model (
    // Clock
    input  wire logic        core_clk,
    // Memory port
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic      [7:0]  mem_rdata
);
    initial mem_rdata = 8'h3C;
    always @(posedge core_clk) begin
        if (mem_rd) begin
            mem_rdata <= mem_addr[7:0] ^ 8'hA5;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : pvi_mem_model

// ===== sim/prioritized_vector_interrupt_unit_tb.sv
// Testbench for pvi_unit: masking, priority, edges, break, reset vector.
// Assumes pvi_mem_model as memory, pc_in, sp_in and ps_in held constant.
`timescale 1ns/1ps

module prioritized_vector_interrupt_unit_tb;
    import pvi_pkg::*;
    logic core_clk, rst, ext_pin_irq_a, ext_pin_irq_b, ext_pin_irq_c;
    logic counter_pin_a, counter_pin_b, serial_done, serial_sel, timer_a_uflow;
    logic adc_done, adc_sel, software_break, enable_wr, req_wr, i_flag_set;
    logic i_flag_clr, instr_boundary, stack_page, mem_wr, mem_rd, halt;
    logic pc_load, sp_load, i_flag;
    logic [3:0]  grant_src;
    logic [4:0]  edge_fall_sel;
    logic [5:0]  timer8_uflow;
    logic [7:0]  keypad_port, keypad_dir, sp_in, ps_in, mem_rdata, mem_wdata, sp_out;
    logic [14:0] enable_wdata, req_wdata, req_status, enable_status;
    logic [15:0] pc_in, mem_addr, pc_out;
    int          failures, compares;
    logic [3:0]  order [14] = '{3, 5, 6, 7, 8, 9, 10, 14, 0, 1, 2, 11, 12, 13};

    pvi_unit dut (.core_clk, .rst, .ext_pin_irq_a, .ext_pin_irq_b, .ext_pin_irq_c,
        .counter_pin_a, .counter_pin_b, .edge_fall_sel, .keypad_port, .keypad_dir,
        .serial_done, .serial_sel, .timer_a_uflow, .timer8_uflow, .adc_done, .adc_sel,
        .software_break, .enable_wr, .enable_wdata, .req_wr, .req_wdata, .i_flag_set,
        .i_flag_clr, .instr_boundary, .pc_in, .sp_in, .ps_in, .stack_page, .mem_rdata,
        .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .halt, .pc_out, .pc_load, .sp_out,
        .sp_load, .i_flag, .grant_src, .req_status, .enable_status);
    pvi_mem_model u_mem (.core_clk, .mem_addr, .mem_rd, .mem_rdata);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task step;
        @(posedge core_clk);
    endtask : step
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    task ev(input logic [15:0] m);
        serial_done <= m[3]; timer_a_uflow <= m[4]; timer8_uflow <= m[10:5];
        adc_done <= m[14]; software_break <= m[15];
        step;
        serial_done <= 0; timer_a_uflow <= 0; timer8_uflow <= 0;
        adc_done <= 0; software_break <= 0;
        repeat (3) step;
    endtask : ev
    task swr(input logic en, input logic [14:0] d);
        enable_wr <= en; enable_wdata <= d; req_wr <= !en; req_wdata <= d;
        step;
        enable_wr <= 0; req_wr <= 0;
        repeat (2) step;
    endtask : swr
    task iclr; i_flag_clr <= 1; step; i_flag_clr <= 0; step; endtask : iclr
    task noacc; instr_boundary <= 1; step; instr_boundary <= 0; step;
        chk("halt", 0, halt); endtask : noacc
    task accept(input logic [3:0] idx, input logic [7:0] ps_exp);
        logic [15:0] v;
        int n, k;
        v = 16'hFFFA - {11'h000, idx, 1'b0};
        n = 0;
        instr_boundary <= 1;
        step;
        instr_boundary <= 0;
        for (k = 0; k < 20 && !pc_load; k++) begin
            if (mem_wr) begin
                chk("push_addr", {7'h00, stack_page, 8'h80 - 8'(n)}, mem_addr);
                chk("push_data", n == 0 ? 8'h12 : n == 1 ? 8'h34 : ps_exp, mem_wdata);
                chk("halt_acc", 1, halt);
                n++;
            end
            step;
        end
        if (k == 20) begin
            failures++;
            summarize();
        end else begin
            chk("pc", {(v[7:0] + 8'h01) ^ 8'hA5, v[7:0] ^ 8'hA5}, pc_out);
            chk("grant", idx, grant_src);
            chk("sp", 8'h7D, sp_out);
            chk("pushes", 3, n);
            chk("sp_load", 1, sp_load);
            chk("i_flag", 1, i_flag);
        end
    endtask : accept

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        int k;
        rst <= 1;
        repeat (6) step;
        rst <= 0;
        for (k = 0; k < 20 && !pc_load; k++) step;
        if (k == 20) begin
            failures++;
            summarize();
        end
        chk("reset_pc", {8'hFD ^ 8'hA5, 8'hFC ^ 8'hA5}, pc_out);
        chk("reset_halt", 0, halt);
        chk("reset_sp_load", 0, sp_load);
        chk("reset_i", 1, i_flag);
        chk("reset_en", 0, enable_status);
        $display("test reset done");
    endtask : t_reset
    task t_mask;
        stack_page <= 0;
        ev(16'h0010);
        chk("req_held", 16'h0010, req_status);
        noacc();
        swr(1, 15'h0010);
        noacc();
        iclr();
        accept(4, 8'h00);
        step;
        chk("req_clr", 0, req_status);
        $display("test mask done");
    endtask : t_mask
    task t_prio;
        stack_page <= 1;
        ev(16'h4008);
        chk("sel_off", 0, req_status);
        serial_sel <= 1; adc_sel <= 1;
        ev(16'h47E8);
        swr(0, 15'h7FFF);
        chk("no_sw_set", 16'h47E8, req_status);
        swr(1, 15'h7FFF);
        for (int i = 0; i < 8; i++) begin iclr(); accept(order[i], 8'h00); end
        ev(16'h0020);
        swr(0, 15'h7FDF);
        chk("sw_clear", 0, req_status);
        $display("test priority done");
    endtask : t_prio
    task t_edges;
        ext_pin_irq_a <= 1; ext_pin_irq_b <= 1; ext_pin_irq_c <= 1;
        counter_pin_a <= 1; counter_pin_b <= 1; keypad_port <= 8'hFE;
        repeat (4) step;
        chk("edges", 16'h3807, req_status);
        for (int i = 8; i < 14; i++) begin iclr(); accept(order[i], 8'h00); end
        swr(1, 15'h7FFE);
        ext_pin_irq_a <= 0;
        repeat (4) step;
        edge_fall_sel <= 5'h01;
        repeat (4) step;
        chk("sel_side", 16'h0001, req_status);
        swr(0, 15'h7FFE);
        chk("sel_clr", 0, req_status);
        swr(1, 15'h7FFF);
        ext_pin_irq_a <= 1;
        repeat (4) step;
        ext_pin_irq_a <= 0;
        repeat (4) step;
        chk("falling", 16'h0001, req_status);
        swr(0, 15'h7FFE);
        keypad_port <= 8'hFF;
        keypad_dir <= 8'h02;
        repeat (2) step;
        keypad_port <= 8'hFD;
        repeat (4) step;
        chk("key_out_pin", 0, req_status);
        keypad_port <= 8'hF9;
        repeat (4) step;
        chk("key_in_pin", 16'h2000, req_status);
        swr(0, 15'h5FFF);
        $display("test edges done");
    endtask : t_edges
    task t_break;
        ev(16'h8000);
        accept(15, 8'h14);
        chk("brk_i", 1, i_flag);
        iclr();
        chk("i_clr", 0, i_flag);
        noacc();
        i_flag_set <= 1;
        step;
        i_flag_set <= 0;
        step;
        chk("i_set", 1, i_flag);
        $display("test break done");
    endtask : t_break

    initial begin
        failures = 0; compares = 0; rst = 1;
        {ext_pin_irq_a, ext_pin_irq_b, ext_pin_irq_c, counter_pin_a, counter_pin_b} = 0;
        {serial_done, serial_sel, timer_a_uflow, adc_done, adc_sel, software_break} = 0;
        {enable_wr, req_wr, i_flag_set, i_flag_clr, instr_boundary, stack_page} = 0;
        edge_fall_sel = 0; timer8_uflow = 0; keypad_port = 8'hFF; keypad_dir = 8'h00;
        enable_wdata = 0; req_wdata = 0; pc_in = 16'h1234; sp_in = 8'h80; ps_in = 8'h00;
        t_reset();
        t_mask();
        t_prio();
        t_edges();
        t_break();
        summarize();
    end
endmodule : prioritized_vector_interrupt_unit_tb
